// file: dspc_pkg.sv
/*
 file holds: constants, register map and state type of the deep sleep power control block
 assumes: apb slave with 32-bit data, one clock pclk at 50 MHz
*/
package dspc_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [11:0] DSPC_REG_REGULATOR  = 12'h000;
	localparam logic [11:0] DSPC_REG_SLEEP      = 12'h004;
	localparam logic [11:0] DSPC_REG_RAM_POWER  = 12'h008;
	localparam logic [11:0] DSPC_REG_STATUS     = 12'h00C;

	// ****************************************
	// fields and values
	// ****************************************
	localparam int          DSPC_RAM_SECTIONS   = 8;
	localparam int          DSPC_SWEN_BIT       = 0;
	localparam logic [31:0] DSPC_SLEEP_ENTER    = 32'h00000001;
	localparam logic        DSPC_SWEN_RESET     = 1'b0;
	localparam logic [7:0]  DSPC_RAM_RESET      = 8'h00;
	localparam int          DSPC_ST_SWREG_BIT   = 0;
	localparam int          DSPC_ST_EMUL_BIT    = 1;
	localparam int          DSPC_ST_WOKE_BIT    = 2;

	// ****************************************
	// timing
	// ****************************************
	localparam int          DSPC_CLK_MHZ        = 50;
	localparam int          DSPC_WAKE_RST_NS    = 200;
	localparam int          DSPC_WAKE_RST_CYC   = (DSPC_WAKE_RST_NS * DSPC_CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  DSPC_WAKE_RST_CNT   = 4'(DSPC_WAKE_RST_CYC);

	typedef enum logic [1:0] {
		DSPC_RUN,
		DSPC_OFF,
		DSPC_EMUL,
		DSPC_WAKE
	} dspc_state_type;
endpackage

// file: dspc_retain.sv
/*
 file holds: per-section ram retention settings, kept across the wake reset
 assumes: only the power-on reset clears them
*/
`timescale 1ns/1ps
module dspc_retain
	import dspc_pkg::*;
(
	input  wire logic                         pclk,
	input  wire logic                         por_n,
	input  wire logic                         wr_en,
	input  wire logic [DSPC_RAM_SECTIONS-1:0] wr_data,
	output logic      [DSPC_RAM_SECTIONS-1:0] rd_data
);
	logic [DSPC_RAM_SECTIONS-1:0] keep_q;

	// ****************************************
	// one setting flop per section, read out through a second register stage on rd_data
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < DSPC_RAM_SECTIONS; g++)
		begin : g_sec
			always_ff @(posedge pclk or negedge por_n)
			begin
				if (!por_n)
					keep_q[g] <= DSPC_RAM_RESET[g];
				else if (wr_en)
					keep_q[g] <= wr_data[g]; // RULE8
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge por_n)
	begin
		if (!por_n)
			rd_data <= DSPC_RAM_RESET;
		else
			rd_data <= keep_q;
	end
endmodule

// file: dspc_wake_timer.sv
/*
 file holds: wake reset pulse stretcher
 assumes: start is a one-cycle pulse
*/
`timescale 1ns/1ps
module dspc_wake_timer
	import dspc_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic start,
	output logic      busy_q
);
	logic [3:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q  <= 4'h0;
			busy_q <= 1'b0;
		end
		else if (start)
		begin
			cnt_q  <= DSPC_WAKE_RST_CNT;
			busy_q <= 1'b1;
		end
		else if (cnt_q != 4'h0)
		begin
			cnt_q  <= cnt_q - 4'h1;
			busy_q <= (cnt_q != 4'h1);
		end
		else
			busy_q <= 1'b0;
	end
endmodule

// file: dspc_top.sv
/*
 file holds: deep sleep power control top, apb register slave and sleep sequencer
 assumes: pin_wake from the gpio logic and debug_mode are synchronous to pclk;
 presetn is the power-on reset of this block
*/
// Operation
// RULE1 - linear regulator used after power-up
// RULE2 - switching regulator only when software enables
// RULE3 - sleep-entry register write enters deep sleep
// RULE4 - deep sleep powers down core, aborts tasks
// RULE5 - wake only on pin detect or reset
// RULE6 - any wakeup resets the system
// RULE7 - keep ram sections marked for retention
// RULE8 - ram settings survive sleep and wake reset
// RULE9 - software finishes dma transfers before sleep
// RULE10 - debug mode only emulates sleep, keeps resources
// RULE11 - emulated sleep keeps processor powered, running
// RULE12 - software loops forever after sleep request
// RULE13 - debug access port spared by wake reset; the code spares it only on wake from emulated sleep
// RULE14 - only the enter value requests sleep
`timescale 1ns/1ps
module dspc_top
	import dspc_pkg::*;
(
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [11:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	input  wire logic [3:0]                   pstrb,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         pin_wake,
	input  wire logic                         debug_mode,
	output logic                              switching_regulator_on,
	output logic                              core_power_on,
	output logic                              cpu_run,
	output logic                              task_abort,
	output logic                              system_reset,
	output logic                              debug_access_port_reset,
	output logic                              debug_keep_on,
	output logic      [DSPC_RAM_SECTIONS-1:0] ram_retain,
	output logic      [DSPC_RAM_SECTIONS-1:0] ram_power
);
	dspc_state_type               state_q;
	dspc_state_type               state_d;
	logic                         swen_q;
	logic                         woke_q;
	logic                         wr_acc;
	logic                         rd_acc;
	logic                         sleep_req;
	logic                         wake_start;
	logic                         wake_busy;
	logic                         wake_from_emul_q;
	logic [DSPC_RAM_SECTIONS-1:0] ram_keep;
	logic [31:0]                  rd_mux;
	logic                         addr_ok;

	// ****************************************
	// apb decode
	// ****************************************
	assign wr_acc  = psel && penable && pready && pwrite;
	assign rd_acc  = psel && !penable && !pwrite;
	assign addr_ok = (paddr == DSPC_REG_REGULATOR) || (paddr == DSPC_REG_SLEEP)
		|| (paddr == DSPC_REG_RAM_POWER) || (paddr == DSPC_REG_STATUS);
	assign sleep_req = wr_acc && (paddr == DSPC_REG_SLEEP) && pstrb[0]
		&& (pwdata == DSPC_SLEEP_ENTER); // RULE14

	// no wait state: setup then access always answers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel && !penable && !addr_ok;
	end

	always_comb
	begin
		rd_mux = 32'h00000000;
		case (paddr)
			DSPC_REG_REGULATOR: rd_mux[DSPC_SWEN_BIT] = swen_q;
			DSPC_REG_RAM_POWER: rd_mux[DSPC_RAM_SECTIONS-1:0] = ram_keep;
			DSPC_REG_STATUS:
			begin
				rd_mux[DSPC_ST_SWREG_BIT] = switching_regulator_on;
				rd_mux[DSPC_ST_EMUL_BIT]  = (state_q == DSPC_EMUL);
				rd_mux[DSPC_ST_WOKE_BIT]  = woke_q;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_acc)
			prdata <= rd_mux;
	end

	// ****************************************
	// regulator select
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			swen_q <= DSPC_SWEN_RESET; // RULE1
		else if (wr_acc && (paddr == DSPC_REG_REGULATOR) && pstrb[0])
			swen_q <= pwdata[DSPC_SWEN_BIT]; // RULE2
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			switching_regulator_on <= 1'b0; // RULE1
		else
			switching_regulator_on <= swen_q; // RULE2
	end

	// ****************************************
	// ram retention settings
	// ****************************************
	dspc_retain u_retain (
		.pclk    (pclk),
		.por_n   (presetn),
		.wr_en   (wr_acc && (paddr == DSPC_REG_RAM_POWER) && pstrb[0]),
		.wr_data (pwdata[DSPC_RAM_SECTIONS-1:0]),
		.rd_data (ram_keep)
	);

	// ****************************************
	// sleep sequencer
	// ****************************************
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			DSPC_RUN:
				if (sleep_req)
					state_d = debug_mode ? DSPC_EMUL : DSPC_OFF; // RULE3 RULE10
			DSPC_OFF:
				if (pin_wake)
					state_d = DSPC_WAKE; // RULE5
			DSPC_EMUL:
				if (pin_wake)
					state_d = DSPC_WAKE; // RULE5
			DSPC_WAKE:
				if (!wake_busy && !wake_start)
					state_d = DSPC_RUN;
			default: state_d = DSPC_RUN;
		endcase
	end

	assign wake_start = (state_q != DSPC_WAKE) && (state_d == DSPC_WAKE);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= DSPC_RUN;
		else
			state_q <= state_d;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_from_emul_q <= 1'b0;
		else if (wake_start)
			wake_from_emul_q <= (state_q == DSPC_EMUL); // RULE13
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			woke_q <= 1'b0;
		else if (wake_start)
			woke_q <= 1'b1;
		else if (wr_acc && (paddr == DSPC_REG_STATUS) && pstrb[0]
			&& pwdata[DSPC_ST_WOKE_BIT])
			woke_q <= 1'b0;
	end

	dspc_wake_timer u_wake (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (wake_start),
		.busy_q  (wake_busy)
	);

	// ****************************************
	// power outputs
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_power_on <= 1'b1;
			cpu_run       <= 1'b1;
			task_abort    <= 1'b0;
			debug_keep_on <= 1'b0;
		end
		else
		begin
			core_power_on <= (state_d != DSPC_OFF); // RULE4 RULE10
			cpu_run       <= (state_d == DSPC_RUN) || (state_d == DSPC_EMUL); // RULE11
			task_abort    <= (state_d == DSPC_OFF) || (state_d == DSPC_EMUL); // RULE4
			debug_keep_on <= (state_d == DSPC_EMUL); // RULE10
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			system_reset            <= 1'b0;
			debug_access_port_reset <= 1'b0;
		end
		else
		begin
			system_reset            <= (state_d == DSPC_WAKE); // RULE6
			debug_access_port_reset <= (state_d == DSPC_WAKE) && !wake_from_emul_q
				&& !(wake_start && (state_q == DSPC_EMUL)); // RULE13
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ram_retain <= DSPC_RAM_RESET;
			ram_power  <= {DSPC_RAM_SECTIONS{1'b1}};
		end
		else
		begin
			ram_retain <= ram_keep; // RULE7
			ram_power  <= (state_d == DSPC_OFF) ? ram_keep : {DSPC_RAM_SECTIONS{1'b1}}; // RULE7
		end
	end
endmodule

// file: dspc_top_checker.sv
/*
 holds: assertions on the ports of the deep sleep power control top
 assumes: bound into dspc_top, one clock pclk, reset presetn
*/
`timescale 1ns/1ps
module dspc_top_checker
	import dspc_pkg::*;
(
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [11:0]                  paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic [3:0]                   pstrb,
	input wire logic                         pready,
	input wire logic                         pin_wake,
	input wire logic                         switching_regulator_on,
	input wire logic                         core_power_on,
	input wire logic                         cpu_run,
	input wire logic                         task_abort,
	input wire logic                         system_reset,
	input wire logic                         debug_access_port_reset,
	input wire logic                         debug_keep_on,
	input wire logic [DSPC_RAM_SECTIONS-1:0] ram_retain,
	input wire logic [DSPC_RAM_SECTIONS-1:0] ram_power
);
	// ****************************************
	// helpers and assertions
	// ****************************************
	logic wr;
	logic sl;
	assign wr = psel && penable && pready && pwrite;
	assign sl = wr && paddr == DSPC_REG_SLEEP && pstrb[0] && pwdata == DSPC_SLEEP_ENTER;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_APB_READY:
	assert property (psel && !penable |=> pready) else $error("no ready after setup");
	AST_SWREG_CAUSE:
	assert property ($rose(switching_regulator_on) |->
		$past(wr && paddr == DSPC_REG_REGULATOR && pstrb[0] && pwdata[DSPC_SWEN_BIT], 2))
		else $error("regulator rise");
	AST_SLEEP_CAUSE:
	assert property ($fell(core_power_on) || $rose(debug_keep_on) |->
		$past(sl) || $past(sl, 2)) else $error("sleep without enter write");
	AST_CORE_DOWN:
	assert property (!core_power_on |-> task_abort && !cpu_run) else $error("core down");
	AST_WAKE_ONLY:
	assert property (!core_power_on && !pin_wake && !system_reset |=> !core_power_on)
		else $error("left sleep without wake");
	AST_WAKE_RESET:
	assert property (task_abort && pin_wake |=> system_reset) else $error("no wake reset");
	AST_WAKE_PULSE:
	assert property ($rose(system_reset) |-> system_reset[*8] ##[1:6] !system_reset)
		else $error("wake reset length");
	AST_RAM_POWER:
	assert property (ram_power == (core_power_on ? {DSPC_RAM_SECTIONS{1'b1}} : ram_retain))
		else $error("ram power");
	AST_RAM_KEEP:
	assert property (!$stable(ram_retain) |->
		$past(wr && paddr == DSPC_REG_RAM_POWER && pstrb[0], 3)) else $error("ram setting lost");
	AST_EMUL_KEEP:
	assert property (debug_keep_on |-> cpu_run && core_power_on) else $error("emulation");
	AST_DAP_SPARED:
	assert property (debug_keep_on && pin_wake |=> !debug_access_port_reset[*8])
		else $error("dap reset");
endmodule

bind dspc_top dspc_top_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .pin_wake(pin_wake), .switching_regulator_on(switching_regulator_on),
	.core_power_on(core_power_on), .cpu_run(cpu_run), .task_abort(task_abort),
	.system_reset(system_reset), .debug_access_port_reset(debug_access_port_reset),
	.debug_keep_on(debug_keep_on), .ram_retain(ram_retain), .ram_power(ram_power));

// file: test_deep_sleep_power_control.sv
/*
 holds: self-checking testbench of the deep sleep power control top
 assumes: apb slave raises pready one cycle after setup, pclk 50 MHz
*/
`timescale 1ns/1ps
module test_deep_sleep_power_control;
	import dspc_pkg::*;
	// ****************************************
	// signals, clock, timeout
	// ****************************************
	logic        pclk, presetn, psel, penable, pwrite, pin_wake, debug_mode;
	logic        pready, pslverr, sw_on, core_on, cpu_run, abort, sys_rst, dap_rst, keep_on;
	logic        rerr, seen, debug_access_port;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0]  retain, rpow;
	logic [3:0]  pstrb, strb;
	int          err_count, comparisons, cycles;
	dspc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_wake(pin_wake), .debug_mode(debug_mode),
		.switching_regulator_on(sw_on), .core_power_on(core_on), .cpu_run(cpu_run),
		.task_abort(abort), .system_reset(sys_rst), .debug_access_port_reset(dap_rst),
		.debug_keep_on(keep_on), .ram_retain(retain), .ram_power(rpow));
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			end_of_test();
		end
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= strb;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask
	task wake;
		@(posedge pclk);
		pin_wake <= 1'b1;
		@(posedge pclk);
		pin_wake <= 1'b0;
		seen = 1'b0;
		debug_access_port = 1'b0;
		repeat (30) @(negedge pclk)
		begin
			seen |= sys_rst;
			debug_access_port |= dap_rst;
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset_regulator;
		chk("regulator", 0, sw_on);
		chk("ram_power", 8'hFF, rpow);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped slverr", 1, rerr);
		chk("unmapped read", 0, rdat);
		apb(1'b1, DSPC_REG_REGULATOR, 32'h2);
		@(negedge pclk);
		chk("regulator even", 0, sw_on);
		apb(1'b1, DSPC_REG_REGULATOR, 32'h1);
		@(negedge pclk);
		chk("regulator on", 1, sw_on);
		apb(1'b0, DSPC_REG_REGULATOR, 32'h0);
		chk("regulator read", 1, rdat);
		$display("test reset and regulator done");
	endtask
	task t_sleep;
		apb(1'b1, DSPC_REG_RAM_POWER, 32'hA5);
		apb(1'b1, DSPC_REG_SLEEP, 32'h2);
		chk("core after bad value", 1, core_on);
		strb = 4'hE;
		apb(1'b1, DSPC_REG_SLEEP, DSPC_SLEEP_ENTER);
		strb = 4'hF;
		chk("core after masked write", 1, core_on);
		apb(1'b1, DSPC_REG_SLEEP, DSPC_SLEEP_ENTER);
		repeat (12) @(negedge pclk);
		chk("core", 0, core_on);
		chk("abort", 2, {abort, cpu_run});
		chk("ram_power", 8'hA5, rpow);
		wake();
		chk("wake reset", 3, {seen, debug_access_port});
		chk("core awake", 3, {core_on, cpu_run});
		chk("retain", 8'hA5, retain);
		apb(1'b0, DSPC_REG_STATUS, 32'h0);
		chk("status after wake", 32'h5, rdat);
		apb(1'b1, DSPC_REG_STATUS, 32'h4);
		apb(1'b0, DSPC_REG_STATUS, 32'h0);
		chk("woke cleared", 32'h1, rdat);
		$display("test sleep done");
	endtask
	task t_emulated;
		@(posedge pclk);
		debug_mode <= 1'b1;
		apb(1'b1, DSPC_REG_SLEEP, DSPC_SLEEP_ENTER);
		repeat (2) @(negedge pclk);
		chk("keep on", 7, {keep_on, core_on, cpu_run});
		apb(1'b0, DSPC_REG_STATUS, 32'h0);
		chk("status emulated", 32'h3, rdat);
		wake();
		chk("emulated wake", 2, {seen, debug_access_port});
		$display("test emulated sleep done");
	endtask
	task t_reset_wake;
		@(posedge pclk);
		debug_mode <= 1'b0;
		apb(1'b1, DSPC_REG_RAM_POWER, 32'h3C);
		apb(1'b1, DSPC_REG_SLEEP, DSPC_SLEEP_ENTER);
		chk("core before reset", 0, core_on);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		chk("reset wake", 3, {core_on, cpu_run});
		chk("power-on state", 32'h000FF, {sw_on, sys_rst, retain, rpow});
		$display("test reset wake done");
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, pin_wake, debug_mode} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		strb = 4'hF;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_regulator();
		t_sleep();
		t_emulated();
		t_reset_wake();
		end_of_test();
	end
endmodule
